// >>> core/fifo_flag_pkg.sv
// constants and types for the offset-programmed fifo flag block
// ----------------------------------------------------------------
// Contract
// - load pin low at reset selects offset programming mode.
// - load pin high at reset makes it a second active-high write enable.
// - four nine-bit offset registers, written and read via data pins.
// - load and write enable low: each write edge fills next offset register.
// - sequence position kept when load rises mid-sequence.
// - load high returns to normal operation; no fifo write while load low.
// - load and both read enables low: read edge shows next offset register.
// - empty offset parts joined into one value n.
// - almost-empty low on read edge when n or fewer words held.
// - almost-empty high on read edge when n plus one or more held.
// - full offset parts joined into one value m.
// - almost-full low when word count reaches depth minus m.
// - almost-full high on write edge when free locations exceed m.
// - almost-full is one flop updated only on write edges.
// - full low at full depth, write edges only, blocks all writes.
// - empty low at zero words, read edges only, blocks all reads.
// - unprogrammed offsets n and m default to seven.
// - reset empties the fifo with empty flag low.
// ----------------------------------------------------------------
package fifo_flag_pkg;
	localparam int          DATA_W      = 9;
	localparam int          COUNT_W     = 19;
	localparam int          DEPTH_DEF   = 65536;
	localparam int          BUF_DEPTH   = 2;
	// offset sequence positions
	localparam logic [1:0]  SEQ_EMPTY_LO = 2'h0;
	localparam logic [1:0]  SEQ_EMPTY_HI = 2'h1;
	localparam logic [1:0]  SEQ_FULL_LO  = 2'h2;
	localparam logic [1:0]  SEQ_FULL_HI  = 2'h3;
	localparam logic [1:0]  SEQ_STEP     = 2'h1;
	// offset reset values: n = m = 7
	localparam logic [8:0]  OFF_LO_RST   = 9'h007;
	localparam logic [8:0]  OFF_HI_RST   = 9'h000;
	localparam logic [8:0]  Q_RST        = 9'h000;

	typedef enum logic {MODE_PROGRAM, MODE_DUAL_WE} mode_t;

	// status pins, all active low
	typedef struct packed {
		logic empty_n;
		logic almost_empty_n;
		logic almost_full_n;
		logic full_n;
	} flags_t;

	localparam flags_t FLAGS_RST = '{empty_n: 1'b0, almost_empty_n: 1'b0,
		almost_full_n: 1'b1, full_n: 1'b1};
endpackage : fifo_flag_pkg

// >>> core/fifo_offset_program_flags.sv
// offset programming port and status flags of a deep synchronous fifo
`timescale 1ns/1ps
`default_nettype none
module fifo_offset_program_flags #(
	parameter int DEPTH = fifo_flag_pkg::DEPTH_DEF
) (
	// core clock and reset
	input  wire logic                              CORE_CLK,
	input  wire logic                              RSTN,
	// fifo clocks, sampled as levels
	input  wire logic                              WCLK,
	input  wire logic                              RCLK,
	// write port
	input  wire logic [fifo_flag_pkg::DATA_W-1:0]  D,
	input  wire logic                              WRITE_ENABLE_PRIMARY_N,
	input  wire logic                              WRITE_ENABLE_SECONDARY_OR_LOAD,
	// read port
	input  wire logic                              READ_ENABLE_PRIMARY_N,
	input  wire logic                              READ_ENABLE_SECONDARY_N,
	output logic      [fifo_flag_pkg::DATA_W-1:0]  Q,
	// status flags
	output fifo_flag_pkg::flags_t                  FLAGS,
	// stream toward the storage array
	output logic                                   STORE_VALID,
	input  wire logic                              STORE_READY,
	output logic      [fifo_flag_pkg::DATA_W-1:0]  STORE_DATA,
	// word from the storage array at the read head
	input  wire logic [fifo_flag_pkg::DATA_W-1:0]  FETCH_DATA,
	output logic                                   FETCH_POP
);
	import fifo_flag_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// widen an 18-bit offset value for comparison without truncation
	function automatic logic [COUNT_W-1:0] widen(input logic [17:0] v);
		widen = {1'b0, v};
	endfunction : widen

	localparam logic [COUNT_W-1:0] DEPTH_W = COUNT_W'(DEPTH);

	// ----------------------------------------------------------------
	// clock edge detection
	// ----------------------------------------------------------------
	logic         wclk_reg;
	logic         rclk_reg;
	wire  logic   wr_edge;
	wire  logic   rd_edge;

	// previous levels of the fifo clocks
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			wclk_reg <= 1'b0;
			rclk_reg <= 1'b0;
		end else begin
			wclk_reg <= WCLK;
			rclk_reg <= RCLK;
		end
	end

	assign wr_edge = WCLK & ~wclk_reg;
	assign rd_edge = RCLK & ~rclk_reg;

	// ----------------------------------------------------------------
	// mode strap
	// ----------------------------------------------------------------
	mode_t mode_reg;

	// strap at reset
	// no async reset here: the strap must see the pin, not a constant;
	// reset has to be held across at least one core clock edge
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			mode_reg <= WRITE_ENABLE_SECONDARY_OR_LOAD ? MODE_DUAL_WE
				: MODE_PROGRAM;
		end
	end

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	wire  logic   prog_mode;
	wire  logic   load_low;
	wire  logic   wen_ok;
	wire  logic   ren_ok;
	wire  logic   buf_ready;
	wire  logic   off_wr;
	wire  logic   off_rd;
	wire  logic   fifo_wr;
	wire  logic   fifo_rd;
	flags_t       flags_reg;

	assign prog_mode = (mode_reg == MODE_PROGRAM);
	assign load_low  = prog_mode & ~WRITE_ENABLE_SECONDARY_OR_LOAD;
	assign wen_ok    = ~WRITE_ENABLE_PRIMARY_N
		& (prog_mode | WRITE_ENABLE_SECONDARY_OR_LOAD);
	assign ren_ok    = ~READ_ENABLE_PRIMARY_N & ~READ_ENABLE_SECONDARY_N;
	assign off_wr    = wr_edge & load_low & ~WRITE_ENABLE_PRIMARY_N;
	assign off_rd    = rd_edge & load_low & ren_ok;
	assign fifo_wr   = wr_edge & wen_ok & ~load_low & flags_reg.full_n
		& buf_ready;
	assign fifo_rd   = rd_edge & ren_ok & ~load_low & flags_reg.empty_n;
	assign FETCH_POP = fifo_rd;

	// ----------------------------------------------------------------
	// offset registers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] offs_reg [4];
	logic [1:0]        seq_reg;
	wire  logic [17:0] n_val;
	wire  logic [17:0] m_val;

	// sequenced offset store
	// one shared position serves writes and readback, which is why the
	// two must not happen in the same period
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			// defaults n = m = 7
			offs_reg[SEQ_EMPTY_LO] <= OFF_LO_RST;
			offs_reg[SEQ_EMPTY_HI] <= OFF_HI_RST;
			offs_reg[SEQ_FULL_LO]  <= OFF_LO_RST;
			offs_reg[SEQ_FULL_HI]  <= OFF_HI_RST;
			seq_reg                <= SEQ_EMPTY_LO;
		end else begin
			if (off_wr) begin
				offs_reg[seq_reg] <= D;
			end
			if (off_wr | off_rd) begin
				seq_reg <= seq_reg + SEQ_STEP;
			end
		end
	end

	assign n_val = {offs_reg[SEQ_EMPTY_HI], offs_reg[SEQ_EMPTY_LO]};
	assign m_val = {offs_reg[SEQ_FULL_HI], offs_reg[SEQ_FULL_LO]};

	// ----------------------------------------------------------------
	// word count and flags
	// ----------------------------------------------------------------
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] count_next;
	wire  logic         ae_next;
	wire  logic         af_next;

	// count after this cycle's accepted write and read
	always_comb begin
		count_next = count_reg;
		if (fifo_wr & ~fifo_rd) begin
			count_next = count_reg + COUNT_W'(1);
		end else if (fifo_rd & ~fifo_wr) begin
			count_next = count_reg - COUNT_W'(1);
		end
	end

	assign ae_next = (count_next > widen(n_val));
	// free locations above m keeps it high
	assign af_next = (count_next + widen(m_val) < DEPTH_W);

	// empty after reset; each flag on its own fifo clock
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			count_reg <= '0;
			flags_reg <= FLAGS_RST;
		end else begin
			count_reg <= count_next;
			if (rd_edge) begin
				flags_reg.empty_n        <= (count_next != '0);
				flags_reg.almost_empty_n <= ae_next;
			end
			if (wr_edge) begin
				flags_reg.full_n        <= (count_next != DEPTH_W);
				flags_reg.almost_full_n <= af_next;
			end
		end
	end

	assign FLAGS = flags_reg;

	// ----------------------------------------------------------------
	// read data register
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] q_reg;

	// empty fifo keeps the last word; offset readback shares the pins
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			q_reg <= Q_RST;
		end else if (off_rd) begin
			q_reg <= offs_reg[seq_reg];
		end else if (fifo_rd) begin
			q_reg <= FETCH_DATA;
		end
	end

	assign Q = q_reg;

	// ----------------------------------------------------------------
	// two-entry write buffer
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
	logic              buf_wp_reg;
	logic              buf_rp_reg;
	logic [1:0]        buf_cnt_reg;
	wire  logic        buf_pop;

	// a stalled storage port refuses writes rather than dropping words
	assign buf_ready   = (buf_cnt_reg != 2'(BUF_DEPTH));
	assign STORE_VALID = (buf_cnt_reg != 2'h0);
	assign buf_pop     = STORE_VALID & STORE_READY;
	assign STORE_DATA  = buf_mem[buf_rp_reg];

	// pointer and occupancy update
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			buf_wp_reg  <= 1'b0;
			buf_rp_reg  <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else begin
			buf_wp_reg  <= buf_wp_reg ^ fifo_wr;
			buf_rp_reg  <= buf_rp_reg ^ buf_pop;
			buf_cnt_reg <= buf_cnt_reg + 2'(fifo_wr) - 2'(buf_pop);
		end
	end

	// storage words hold no reset value
	always_ff @(posedge CORE_CLK) begin
		if (fifo_wr) begin
			buf_mem[buf_wp_reg] <= D;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_EMPTY_ZERO: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		rd_edge |=> (flags_reg.empty_n == (count_reg != '0)))
		else $error("empty flag disagrees with word count");

	AST_FULL_DEPTH: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		wr_edge |=> (flags_reg.full_n == (count_reg != DEPTH_W)))
		else $error("full flag disagrees with word count");

	AST_NO_WRITE_FULL: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		!flags_reg.full_n |-> !fifo_wr ##1 (count_reg <= DEPTH_W))
		else $error("write taken while full");

	AST_NO_READ_EMPTY: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		!flags_reg.empty_n |-> !fifo_rd && !FETCH_POP
			##1 (count_reg >= $past(count_reg)))
		else $error("read taken while empty");

	AST_SEQ_ADVANCE: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		off_wr |=> ((seq_reg - $past(seq_reg)) == SEQ_STEP)
			&& (offs_reg[$past(seq_reg)] == $past(D)))
		else $error("offset write did not store and advance");

	AST_SEQ_HOLD: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		(!off_wr && !off_rd) |=> $stable(seq_reg))
		else $error("offset position moved without access");

	AST_LOAD_BLOCKS: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		load_low |-> !fifo_wr ##1 $stable(buf_wp_reg))
		else $error("fifo written while load low");

	AST_AE_THRESH: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		rd_edge |=> (flags_reg.almost_empty_n
			== (count_reg > widen($past(n_val)))))
		else $error("almost-empty threshold wrong");

	AST_AF_THRESH: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		wr_edge |=> (flags_reg.almost_full_n
			== (count_reg + widen($past(m_val)) < DEPTH_W)))
		else $error("almost-full threshold wrong");

	AST_OFF_READ: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		off_rd |=> (Q == $past(offs_reg[seq_reg])))
		else $error("offset readback wrong");

	AST_AF_WCLK_ONLY: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		!wr_edge |=> $stable(flags_reg.almost_full_n)
			&& $stable(flags_reg.full_n))
		else $error("write-side flag moved off a write edge");

	AST_STRAP_MODE: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		$rose(RSTN)
			|-> (prog_mode == !$past(WRITE_ENABLE_SECONDARY_OR_LOAD)))
		else $error("mode does not follow the reset strap");

	AST_DUAL_PIN: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		(!prog_mode && !WRITE_ENABLE_SECONDARY_OR_LOAD) |-> !fifo_wr)
		else $error("dual-enable write taken with second enable low");

	AST_LOAD_FREEZE: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		load_low |=> $stable(count_reg))
		else $error("word count moved while load low");

	AST_FETCH_TO_Q: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		fifo_rd |=> (Q == $past(FETCH_DATA)))
		else $error("read word not placed on outputs");

	AST_RD_FLAGS_RCLK_ONLY: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		!rd_edge |=> $stable(flags_reg.empty_n)
			&& $stable(flags_reg.almost_empty_n))
		else $error("read-side flag moved off a read edge");

	AST_COUNT_BOUND: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		count_reg <= DEPTH_W)
		else $error("word count beyond depth");

	AST_DEFAULT_OFFSETS: assert property (
		@(posedge CORE_CLK) disable iff (!RSTN)
		$rose(RSTN) |-> (n_val == {OFF_HI_RST, OFF_LO_RST})
			&& (m_val == {OFF_HI_RST, OFF_LO_RST})
			&& (seq_reg == SEQ_EMPTY_LO))
		else $error("offsets or position not at defaults after reset");
endmodule : fifo_offset_program_flags
`default_nettype wire

// >>> verification/fifo_offset_program_flags_tb.sv
// self-checking bench for the fifo flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) \
	begin error_cnt++; $display("ERROR %s exp %h got %h", nm, exp, got); \
	end end
module fifo_offset_program_flags_tb;
	import fifo_flag_pkg::*;
	localparam int DEPTH = 32;
	localparam int N = 2;
	localparam int M = 3;
	logic         clk = 0, rstn = 0, wclk = 0, rclk = 0, stall = 0;
	logic         wen_n = 1, ld = 1, read_enable_primary_n_n = 1, read_enable_secondary_n_n = 1;
	logic         store_valid, store_ready, fetch_pop;
	logic [8:0]   d = 9'h000, q, store_data, fetch_data;
	flags_t       flags;
	flags_t       flags_b;
	logic         wide_empty_n, wide_full_n;
	int           error_cnt = 0, total_checks = 0, words, c;

	// ----
	// clock, dut, storage model
	// ----
	always #2.5 clk = ~clk;
	fifo_offset_program_flags #(.DEPTH(DEPTH)) dut_u (.CORE_CLK(clk),
		.RSTN(rstn), .WCLK(wclk), .RCLK(rclk), .D(d),
		.WRITE_ENABLE_PRIMARY_N(wen_n), .WRITE_ENABLE_SECONDARY_OR_LOAD(ld),
		.READ_ENABLE_PRIMARY_N(read_enable_primary_n_n), .READ_ENABLE_SECONDARY_N(read_enable_secondary_n_n),
		.Q(q), .FLAGS(flags), .STORE_VALID(store_valid),
		.STORE_READY(store_ready), .STORE_DATA(store_data),
		.FETCH_DATA(fetch_data), .FETCH_POP(fetch_pop));
	fifo_store_model model_u (.clk(clk), .rst_n(rstn), .stall(stall),
		.store_valid(store_valid), .store_ready(store_ready),
		.store_data(store_data), .fetch_data(fetch_data),
		.fetch_pop(fetch_pop), .word_cnt(words));
	// second slice of a width-expanded pair; its second
	// read enable is grounded, end flags merged, almost flags from one
	fifo_offset_program_flags #(.DEPTH(DEPTH)) dut_b_u (.CORE_CLK(clk),
		.RSTN(rstn), .WCLK(wclk), .RCLK(rclk), .D(d),
		.WRITE_ENABLE_PRIMARY_N(wen_n), .WRITE_ENABLE_SECONDARY_OR_LOAD(ld),
		.READ_ENABLE_PRIMARY_N(read_enable_primary_n_n), .READ_ENABLE_SECONDARY_N(1'b0),
		.Q(), .FLAGS(flags_b), .STORE_VALID(), .STORE_READY(store_ready),
		.STORE_DATA(), .FETCH_DATA(fetch_data), .FETCH_POP());
	assign wide_empty_n = flags.empty_n & flags_b.empty_n;
	assign wide_full_n  = flags.full_n & flags_b.full_n;

	// ----
	// access tasks, driven on falling edges
	// ----
	// strap level held steady through reset
	task automatic rst(input logic strap);
		@(negedge clk);
		rstn = 1'b0;
		ld = strap;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
	endtask : rst
	task automatic wr(input logic [8:0] v, input logic en_n, input logic l);
		@(negedge clk);
		d = v;
		wen_n = en_n;
		ld = l;
		wclk = 1'b1;
		@(negedge clk);
		wclk = 1'b0;
		wen_n = 1'b1;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic l);
		@(negedge clk);
		ld = l;
		read_enable_primary_n_n = 1'b0;
		read_enable_secondary_n_n = 1'b0;
		rclk = 1'b1;
		@(negedge clk);
		rclk = 1'b0;
		read_enable_primary_n_n = 1'b1;
		read_enable_secondary_n_n = 1'b1;
	endtask : rd
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	// ----
	// test sequence
	// ----
	initial begin
		rst(1'b0); // load held low at reset
		`CHK("flags", FLAGS_RST, flags)
		`CHK("q", Q_RST, q)
		for (int i = 0; i < 4; i++) begin
			rd(1'b0);
			`CHK("dflt", (i[0] ? OFF_HI_RST : OFF_LO_RST), q)
		end
		// writes and reads kept in separate phases
		wr(N[8:0], 1'b0, 1'b0);
		wr(9'h000, 1'b0, 1'b0);
		wr(M[8:0], 1'b0, 1'b0);
		wr(9'h000, 1'b1, 1'b1);
		wr(9'h000, 1'b0, 1'b0);
		`CHK("stored", 0, words)
		for (int i = 0; i < 4; i++) begin
			rd(1'b0);
			`CHK("offs", (i == 0 ? N[8:0] : i == 2 ? M[8:0] : 9'h000), q)
		end
		// far side stalls: third word refused by full buffer
		stall = 1'b1;
		for (int v = 1; v <= 3; v++)
			wr(v[8:0], 1'b0, 1'b1);
		`CHK("held", 1'b1, store_valid)
		stall = 1'b0;
		repeat (3) @(negedge clk);
		`CHK("drain", 2, words)
		// fill to full and one over
		for (int v = 3; v <= DEPTH + 1; v++) begin
			wr(v[8:0], 1'b0, 1'b1);
			c = (v > DEPTH) ? DEPTH : v;
			`CHK("full", 1'(c != DEPTH), flags.full_n)
			`CHK("afull", 1'(c + M < DEPTH), flags.almost_full_n)
			`CHK("wide ff", 1'(c != DEPTH), wide_full_n)
		end
		`CHK("over", DEPTH, words)
		// empty flag still stale: first read refused, flags wake
		rd(1'b1);
		`CHK("blocked", 9'h000, q)
		`CHK("ef wake", 1'b1, flags.empty_n)
		`CHK("ae wake", 1'b1, flags.almost_empty_n)
		// drain and one read past empty
		for (int k = 1; k <= DEPTH + 1; k++) begin
			rd(1'b1);
			c = (k > DEPTH) ? 0 : DEPTH - k;
			`CHK("data", (k > DEPTH ? DEPTH : k) & 9'h1FF, q)
			`CHK("empty", 1'(c != 0), flags.empty_n)
			`CHK("wide ef", 1'(c != 0), wide_empty_n)
			`CHK("aempty", 1'(c > N), flags.almost_empty_n)
		end
		// write-side flags wait for a write edge
		`CHK("af hold", 1'b0, flags.almost_full_n)
		`CHK("ff hold", 1'b0, flags.full_n)
		rst(1'b1);
		`CHK("flags", FLAGS_RST, flags)
		wr(9'h1A5, 1'b0, 1'b1);
		wr(9'h05A, 1'b0, 1'b0);
		`CHK("dual", 1, words)
		// stale empty flag refuses the first read
		rd(1'b1);
		`CHK("dual blk", Q_RST, q)
		rd(1'b1);
		`CHK("dual q", 9'h1A5, q)
		print_verdict;
	end
	// hang guard, far beyond the expected run
	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end
endmodule : fifo_offset_program_flags_tb
`default_nettype wire

// >>> verification/fifo_store_model.sv
// storage array stand-in behind the flag block's stream ports
`timescale 1ns/1ps
`default_nettype none
module fifo_store_model (
	// clock, reset and stall control
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	input  wire logic                             stall,
	// write stream from the block
	input  wire logic                             store_valid,
	output logic                                  store_ready,
	input  wire logic [fifo_flag_pkg::DATA_W-1:0] store_data,
	// read head toward the block
	output logic      [fifo_flag_pkg::DATA_W-1:0] fetch_data,
	input  wire logic                             fetch_pop,
	output int                                    word_cnt
);
	import fifo_flag_pkg::*;
	logic [DATA_W-1:0] mem [0:63];
	logic [DATA_W-1:0] last_reg;
	int                wp;
	int                rp;
	// stall holds ready low so the block's buffer must absorb words
	assign store_ready = !stall;
	// empty head shows an inverted stale word, not a held one
	assign fetch_data = (wp != rp) ? mem[rp[5:0]] : ~last_reg;
	assign word_cnt = wp - rp;
	// accept on handshake, advance head on pop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp <= 0;
			rp <= 0;
			last_reg <= '0;
		end else begin
			if (store_valid && store_ready) begin
				mem[wp[5:0]] <= store_data;
				wp <= wp + 1;
			end
			if (fetch_pop) begin
				last_reg <= mem[rp[5:0]];
				rp <= rp + 1;
			end
		end
	end
endmodule : fifo_store_model
`default_nettype wire
